/* shared/fmr_pkg.sv */
package fmr_pkg;

    // operation codes presented by the instruction decoder
    typedef enum logic [2:0] {
        FMR_OP_MOVE_TO_WORK,
        FMR_OP_MOVE_TO_MEMORY,
        FMR_OP_OR_TO_WORK,
        FMR_OP_OR_TO_MEMORY,
        FMR_OP_ROTATE_LEFT,
        FMR_OP_ROTATE_LEFT_TO_WORK,
        FMR_OP_ROTATE_LEFT_CARRY,
        FMR_OP_ROTATE_LEFT_CARRY_TO_WORK
    } fmr_op_t;

    // widths and reset values
    localparam int FMR_DATA_W = 8;
    localparam int FMR_ADDR_W = 16;
    localparam logic [7:0] FMR_WORK_RESET = 8'h00;
    localparam logic FMR_FLAG_RESET = 1'b0;

endpackage : fmr_pkg

/* src/fmr_data_mem.sv */
// small single-port data memory with registered read data
module fmr_data_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 8
) (
    // clock
    input wire logic clk,
    // access
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data
);

    typedef logic [DATA_W-1:0] fmr_word_t;
    typedef fmr_word_t fmr_mem_t [0:(1<<ADDR_W)-1];

    // power-up contents: each word holds the low bits of its own address,
    // so that every byte is known before any move has written it
    function automatic fmr_mem_t fmr_fill();
        fmr_mem_t m;
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            m[i] = fmr_word_t'(i);
        end
        return m;
    endfunction : fmr_fill

    fmr_mem_t mem = fmr_fill();

    // write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    // registered read, old data on a same-cycle write
    always_ff @(posedge clk) begin
        rd_data <= mem[addr];
    end

endmodule : fmr_data_mem

/* src/fmr_exec.sv */
// What this block does
// - move to work loads the addressed byte into work, flags unchanged.
// - move to memory writes work into the addressed byte, flags unchanged.
// - or to work puts work OR byte into work, only zero flag changes.
// - or to memory writes work OR byte back, only zero flag changes.
// - rotate left moves byte bit 7 into bit 0 in memory, no flags.
// - rotate left to work puts rotated byte in work, memory and flags kept.
// - rotate left carry in memory: old carry to bit 0, bit 7 to carry.
// - rotate left carry to work: nine-bit result to work and carry, memory kept.
module fmr_exec #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request from the instruction decoder
    input wire logic req_valid,
    output logic req_ready,
    input wire fmr_pkg::fmr_op_t req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    // completion
    output logic done,
    // architectural state
    output logic [7:0] work,
    output logic carry,
    output logic zero
);

    typedef enum logic [1:0] {
        FMR_IDLE,
        FMR_READ,
        FMR_EXEC
    } fmr_state_t;

    fmr_state_t state;
    fmr_pkg::fmr_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] mem_rd;
    logic [7:0] result;
    logic res_carry;
    logic to_mem;
    logic mem_wr;
    logic [7:0] or_byte;
    logic [7:0] rot_plain;
    logic [7:0] rot_carry;
    logic to_work;
    logic sets_carry;
    logic sets_zero;
    logic work_wr;
    logic carry_wr;
    logic zero_wr;
    logic next_zero;

    // data memory, one-cycle registered read
    fmr_data_mem #(
        .DATA_W(fmr_pkg::FMR_DATA_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .clk(clk),
        .addr(addr),
        .wr_en(mem_wr),
        .wr_data(result),
        .rd_data(mem_rd)
    );

    // handshake and completion, decoded from the state
    assign req_ready = (state == FMR_IDLE);
    assign done = (state == FMR_EXEC);

    // sequencer: accept, read the byte, execute
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= FMR_IDLE;
        end else begin
            case (state)
                FMR_IDLE: begin
                    if (req_valid) begin
                        state <= FMR_READ;
                    end
                end
                FMR_READ: state <= FMR_EXEC;
                FMR_EXEC: state <= FMR_IDLE;
                default: state <= FMR_IDLE;
            endcase
        end
    end

    // latch the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op <= fmr_pkg::FMR_OP_MOVE_TO_WORK;
            addr <= '0;
        end else if (req_valid && req_ready) begin
            op <= req_op;
            addr <= req_addr;
        end
    end

    // operands, formed once and picked by the operation
    assign or_byte = work | mem_rd;
    assign rot_plain = {mem_rd[6:0], mem_rd[7]};
    assign rot_carry = {mem_rd[6:0], carry};

    // operation decode: where the result goes, which flag it may touch
    always_comb begin
        to_mem = 1'b0;
        to_work = 1'b0;
        sets_carry = 1'b0;
        sets_zero = 1'b0;
        case (op)
            // moves touch no flag
            fmr_pkg::FMR_OP_MOVE_TO_WORK: begin
                to_work = 1'b1;
            end
            fmr_pkg::FMR_OP_MOVE_TO_MEMORY: begin
                to_mem = 1'b1;
            end
            // or touches the zero flag only
            fmr_pkg::FMR_OP_OR_TO_WORK: begin
                to_work = 1'b1;
                sets_zero = 1'b1;
            end
            fmr_pkg::FMR_OP_OR_TO_MEMORY: begin
                to_mem = 1'b1;
                sets_zero = 1'b1;
            end
            // plain rotates touch no flag
            fmr_pkg::FMR_OP_ROTATE_LEFT: begin
                to_mem = 1'b1;
            end
            fmr_pkg::FMR_OP_ROTATE_LEFT_TO_WORK: begin
                to_work = 1'b1;
            end
            // rotates through carry touch the carry flag only
            fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY: begin
                to_mem = 1'b1;
                sets_carry = 1'b1;
            end
            default: begin
                to_work = 1'b1;
                sets_carry = 1'b1;
            end
        endcase
    end

    // result datapath
    always_comb begin
        result = mem_rd;
        res_carry = carry;
        case (op)
            // moves
            fmr_pkg::FMR_OP_MOVE_TO_WORK: begin
                result = mem_rd;
            end
            fmr_pkg::FMR_OP_MOVE_TO_MEMORY: begin
                result = work;
            end
            // or of work and the byte
            fmr_pkg::FMR_OP_OR_TO_WORK: begin
                result = or_byte;
            end
            fmr_pkg::FMR_OP_OR_TO_MEMORY: begin
                result = or_byte;
            end
            // plain rotates, bit 7 wraps to bit 0
            fmr_pkg::FMR_OP_ROTATE_LEFT: begin
                result = rot_plain;
            end
            fmr_pkg::FMR_OP_ROTATE_LEFT_TO_WORK: begin
                result = rot_plain;
            end
            // rotates through carry, bit 7 leaves into carry
            fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY: begin
                result = rot_carry;
                res_carry = mem_rd[7];
            end
            default: begin
                result = rot_carry;
                res_carry = mem_rd[7];
            end
        endcase
    end

    // write strobes, all confined to the execute cycle
    assign mem_wr = done && to_mem;
    assign work_wr = done && to_work;
    assign carry_wr = done && sets_carry;
    assign zero_wr = done && sets_zero;

    // zero test on the eight-bit result
    assign next_zero = (result == 8'h00);

    // work register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            work <= fmr_pkg::FMR_WORK_RESET;
        end else if (work_wr) begin
            work <= result;
        end
    end

    // carry flag, written only by the rotates through carry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            carry <= fmr_pkg::FMR_FLAG_RESET;
        end else if (carry_wr) begin
            carry <= res_carry;
        end
    end

    // zero flag, written only by the or operations
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zero <= fmr_pkg::FMR_FLAG_RESET;
        end else if (zero_wr) begin
            zero <= next_zero;
        end
    end

endmodule : fmr_exec

/* tb/fmr_exec_chk.sv */
module fmr_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request, results
    input wire logic req_valid,
    input wire logic req_ready,
    input wire fmr_pkg::fmr_op_t req_op,
    input wire logic done,
    input wire logic [7:0] work,
    input wire logic carry,
    input wire logic zero
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    fmr_pkg::fmr_op_t op_q;
    // op of the request in flight
    always_ff @(posedge clk) begin
        if (req_valid && req_ready) op_q <= req_op;
    end
    // read cycle then execute cycle
    sequence s_run;
        !req_ready ##1 (done && !req_ready);
    endsequence
    a_done_timing: assert property (req_valid && req_ready |=> s_run)
        else $error("done late");
    a_done_pulse: assert property (done |=> !done && req_ready) else $error("done long");
    a_work_hold: assert property (!done |=> $stable(work)) else $error("work moved");
    a_zero_hold: assert property (!done |=> $stable(zero)) else $error("zero moved");
    a_flags_kept: assert property (done && op_q inside {0, 1, 4, 5} |=> $stable({carry, zero}))
        else $error("flag moved");
    a_or_zero: assert property (done && op_q == 2 |=> zero == (work == 8'h00))
        else $error("zero wrong");
    a_mem_work: assert property (done && op_q inside {1, 3, 4, 6} |=> $stable(work))
        else $error("work moved");
    a_carry_bit0: assert property (done && op_q == 7 |=> work[0] == $past(carry))
        else $error("bit 0 wrong");
endmodule : fmr_chk
bind fmr_exec fmr_chk u_fmr_chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .done(done), .work(work), .carry(carry),
    .zero(zero));

/* tb/fmr_decoder.sv */
module fmr_decoder (
    // clock and bench command
    input wire logic clk,
    input wire logic cmd_go,
    input wire fmr_pkg::fmr_op_t cmd_op,
    input wire logic [7:0] cmd_addr,
    // request side
    input wire logic req_ready,
    output logic req_valid,
    output fmr_pkg::fmr_op_t req_op,
    output logic [7:0] req_addr
);
    initial begin
        req_valid = 1'b0;
        req_op = fmr_pkg::FMR_OP_MOVE_TO_WORK;
        req_addr = 8'h00;
    end
    // hold the request until taken, then scramble the stale address
    always @(posedge clk) begin
        if (cmd_go) begin
            req_valid <= 1'b1;
            req_op <= cmd_op;
            req_addr <= cmd_addr;
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req_addr <= ~req_addr;
        end
    end
endmodule : fmr_decoder

/* tb/test_far_move_or_rotate_left_exec.sv */
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: mismatch", $time); end end
module test_far_move_or_rotate_left_exec;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, go = 0, req_valid, req_ready, done, carry, zero;
    fmr_pkg::fmr_op_t op = fmr_pkg::FMR_OP_MOVE_TO_WORK, req_op;
    logic [7:0] addr = 8'h00, req_addr, work;
    int n_fail = 0, n_tests = 0;
    always #2 clk = ~clk;
    fmr_decoder u_fmr_decoder (.clk(clk), .cmd_go(go), .cmd_op(op), .cmd_addr(addr),
        .req_ready(req_ready), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr));
    fmr_exec u_fmr_exec (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .done(done),
        .work(work), .carry(carry), .zero(zero));
    task results;
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    // one operation, ends at a falling edge with results visible
    task run(input fmr_pkg::fmr_op_t o, input logic [7:0] a);
        @(posedge clk) begin go <= 1'b1; op <= o; addr <= a; end
        @(posedge clk) go <= 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) @(negedge clk);
        `CHK(done, 1'b1)
        @(negedge clk);
    endtask : run
    // memory words power up holding their own address; checks are {work, carry, zero}, with req_ready in front after reset
    task t_move;
        @(negedge clk);
        `CHK({req_ready, work, carry, zero}, 11'h400)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h96);
        `CHK({work, carry, zero}, 10'h258)
        run(fmr_pkg::FMR_OP_MOVE_TO_MEMORY, 8'h10);
        `CHK({work, carry, zero}, 10'h258)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h00);
        `CHK({work, carry, zero}, 10'h000)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h10);
        `CHK({work, carry, zero}, 10'h258)
    endtask : t_move
    // byte 41 becomes d7; a zero result sets the flag, a plain rotate keeps it
    task t_or;
        run(fmr_pkg::FMR_OP_OR_TO_MEMORY, 8'h41);
        `CHK({work, carry, zero}, 10'h258)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h00);
        `CHK({work, carry, zero}, 10'h000)
        run(fmr_pkg::FMR_OP_OR_TO_WORK, 8'h00);
        `CHK({work, carry, zero}, 10'h001)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_TO_WORK, 8'h00);
        `CHK({work, carry, zero}, 10'h001)
        run(fmr_pkg::FMR_OP_OR_TO_WORK, 8'h41);
        `CHK({work, carry, zero}, 10'h35c)
    endtask : t_or
    // rotates with carry going in and out, memory read back by moves
    task t_rot;
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY_TO_WORK, 8'h81);
        `CHK({work, carry, zero}, 10'h00a)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY, 8'h41);
        `CHK({work, carry, zero}, 10'h00a)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h41);
        `CHK({work, carry, zero}, 10'h2be)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_TO_WORK, 8'h81);
        `CHK({work, carry, zero}, 10'h00e)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT, 8'h10);
        `CHK({work, carry, zero}, 10'h00e)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h10);
        `CHK({work, carry, zero}, 10'h0b6)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY, 8'h22);
        `CHK({work, carry, zero}, 10'h0b4)
        run(fmr_pkg::FMR_OP_ROTATE_LEFT_CARRY_TO_WORK, 8'h22);
        `CHK({work, carry, zero}, 10'h228)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h81);
        `CHK({work, carry, zero}, 10'h204)
    endtask : t_rot
    // reset while idle between operations: state returns to reset values, memory keeps its bytes
    task t_reset;
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK({req_ready, work, carry, zero}, 11'h400)
        run(fmr_pkg::FMR_OP_MOVE_TO_WORK, 8'h41);
        `CHK({work, carry, zero}, 10'h2bc)
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_move();
        t_or();
        t_rot();
        t_reset();
        results();
    end
    initial begin
        #5000;
        n_fail++;
        results();
    end
endmodule : test_far_move_or_rotate_left_exec
